// ---- core/gateway_status_handshake_mapper.sv ----
`timescale 1ns/10ps
`include "gw_defines.svh"
module gateway_status_handshake_mapper (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input gw_pkg::subnet_event_type events,
  input wire logic all_data_updated,
  input wire logic [5:0] lookup_attr,
  output gw_pkg::map_entry_type lookup_entry,
  output logic default_poll_mode,
  output logic modbus_enable,
  output logic [4:0] control_code,
  output logic [7:0] control_data
);
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    gw_pkg::control_word_type ctl;
    gw_pkg::status_word_type sts;
    logic seen_dv;
    logic [4:0] seen_code;
    logic [7:0] seen_data;
    logic hs_enable;
    logic started;
    logic [6:0] mb_index;
    logic [`MB_WORDS-1:0][15:0] mbox;
    gw_pkg::mapper_state_type map_state;
    logic [5:0] map_i;
    logic [6:0] map_count;
    logic mb_done;
    logic mb_accepted;
  } main_state_type;

  main_state_type s;
  main_state_type next_s;

  logic [4:0] enc_code;
  logic [7:0] enc_data;
  logic table_clear;
  gw_pkg::map_write_type table_wr;
  logic do_write;
  logic header_ok;
  logic entry_ok;
  logic want_dv;
  logic [6:0] off_idx;
  logic [6:0] len_idx;
  logic [15:0] entry_off;
  logic [15:0] entry_len;
  logic [16:0] entry_end;
  logic [15:0] size_bytes;
  logic [31:0] read_word;
  logic [1:0] read_resp;

  status_encoder u_encoder (
    .aclk(aclk),
    .aresetn(aresetn),
    .events(events),
    .code(enc_code),
    .data(enc_data)
  );

  map_table u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(table_clear),
    .wr(table_wr),
    .lookup_attr(lookup_attr),
    .lookup_entry(lookup_entry),
    .default_poll_mode(default_poll_mode)
  );

  always_comb begin
    next_s = s;
    do_write = s.aw_held && s.w_held && !s.bvalid;
    table_clear = 1'b0;
    table_wr = '0;
    size_bytes = s.mbox[`MB_W_SIZE];
    header_ok = s.mbox[`MB_W_INFO] == `MB_INFO_CMD && s.mbox[`MB_W_CMD] == `MB_CMD_IN_MAP
      && s.mbox[`MB_W_FCOUNT] == `MB_FRAME_ONE && s.mbox[`MB_W_FNUM] == `MB_FRAME_ONE
      && size_bytes[1:0] == 2'b00 && size_bytes <= `MB_MAX_BYTES;
    off_idx = `MB_HDR_WORDS + {s.map_i, 1'b0};
    len_idx = off_idx + 7'h01;
    entry_off = s.mbox[off_idx];
    entry_len = s.mbox[len_idx];
    entry_end = {1'b0, entry_off} + {1'b0, entry_len};
    entry_ok = entry_end <= `PARAM_IN_BYTES;

    // Write channels are taken independently and joined once both are held.
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      unique case (s.awaddr)
        `ADDR_CONTROL: begin
          if (s.wstrb[0]) begin
            next_s.ctl[7:0] = s.wdata[7:0];
          end
          if (s.wstrb[1]) begin
            next_s.ctl[15:8] = s.wdata[15:8];
          end
        end
        `ADDR_STATUS: begin
        end
        `ADDR_CONFIG: begin
          if (s.wstrb[0]) begin
            next_s.hs_enable = s.wdata[`CONFIG_HS_ENABLE];
          end
        end
        `ADDR_MB_INDEX: begin
          if (s.wstrb[0]) begin
            next_s.mb_index = s.wdata[6:0];
          end
        end
        `ADDR_MB_DATA: begin
          // The buffer is frozen while a command runs so the response stays coherent.
          if (s.map_state == gw_pkg::MAP_IDLE && s.mb_index < 7'(`MB_WORDS)) begin
            if (s.wstrb[0]) begin
              next_s.mbox[s.mb_index][7:0] = s.wdata[7:0];
            end
            if (s.wstrb[1]) begin
              next_s.mbox[s.mb_index][15:8] = s.wdata[15:8];
            end
            next_s.mb_index = s.mb_index + 7'h01;
          end
        end
        `ADDR_MB_CTRL: begin
          if (s.wstrb[0] && s.wdata[`MB_GO] && s.map_state == gw_pkg::MAP_IDLE) begin
            next_s.map_state = gw_pkg::MAP_CHECK;
            next_s.mb_done = 1'b0;
            next_s.mb_accepted = 1'b0;
          end
        end
        default: begin
          next_s.bresp = `RESP_SLVERR;
        end
      endcase
    end

    read_resp = `RESP_OKAY;
    unique case (araddr)
      `ADDR_CONTROL: read_word = {16'h0000, s.ctl};
      `ADDR_STATUS: read_word = {16'h0000, s.sts};
      `ADDR_CONFIG: read_word = {31'h00000000, s.hs_enable};
      `ADDR_MB_INDEX: read_word = {25'h0000000, s.mb_index};
      `ADDR_MB_DATA: begin
        read_word = 32'h00000000;
        if (s.mb_index < 7'(`MB_WORDS)) begin
          read_word = {16'h0000, s.mbox[s.mb_index]};
        end
      end
      `ADDR_MB_CTRL: read_word = {29'h00000000, s.mb_accepted, s.mb_done,
        s.map_state != gw_pkg::MAP_IDLE};
      default: begin
        read_word = 32'h00000000;
        read_resp = `RESP_SLVERR;
      end
    endcase
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_word;
      next_s.rresp = read_resp;
    end

    // Control content is only acted on when its toggle shows a new posting.
    if (s.ctl.toggle != s.sts.confirm) begin
      next_s.seen_dv = s.ctl.data_valid;
      next_s.seen_code = s.ctl.code;
      next_s.seen_data = s.ctl.data;
      next_s.sts.confirm = s.ctl.toggle;
    end
    if (s.hs_enable && s.seen_dv) begin
      next_s.started = 1'b1;
    end

    // Status data-valid follows the controller's flag and waits for the
    // sub-network to finish its first full update, which may take long.
    want_dv = s.seen_dv && all_data_updated;
    if ({want_dv, enc_code, enc_data} != {s.sts.data_valid, s.sts.code, s.sts.data}
        && (!s.hs_enable || s.ctl.confirm == s.sts.toggle)) begin
      next_s.sts.data_valid = want_dv;
      next_s.sts.code = enc_code;
      next_s.sts.data = enc_data;
      next_s.sts.toggle = !s.sts.toggle;
    end

    unique case (s.map_state)
      gw_pkg::MAP_IDLE: begin
      end
      gw_pkg::MAP_CHECK: begin
        next_s.mb_accepted = header_ok;
        next_s.map_i = 6'h00;
        next_s.map_count = size_bytes[8:2];
        table_clear = header_ok;
        if (header_ok && size_bytes[8:2] != 7'h00) begin
          next_s.map_state = gw_pkg::MAP_ENTRY;
        end else begin
          next_s.map_state = gw_pkg::MAP_DONE;
        end
      end
      gw_pkg::MAP_ENTRY: begin
        table_wr.en = 1'b1;
        table_wr.index = s.map_i;
        if (entry_ok) begin
          table_wr.entry.exists = entry_len != 16'h0000;
          table_wr.entry.offset = entry_off;
          table_wr.entry.length = entry_len;
        end else begin
          next_s.mbox[off_idx] = 16'h0000;
          next_s.mbox[len_idx] = 16'h0000;
        end
        next_s.map_i = s.map_i + 6'h01;
        if ({1'b0, s.map_i} + 7'h01 == s.map_count) begin
          next_s.map_state = gw_pkg::MAP_DONE;
        end
      end
      gw_pkg::MAP_DONE: begin
        next_s.mbox[`MB_W_INFO] = s.mb_accepted ? `MB_INFO_RSP : `MB_INFO_REJECT;
        next_s.mb_done = 1'b1;
        next_s.map_state = gw_pkg::MAP_IDLE;
      end
      default: begin
        next_s.map_state = gw_pkg::MAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.sts.code <= `CODE_NO_ERROR;
      s.hs_enable <= `CONFIG_RESET;
      s.map_state <= gw_pkg::MAP_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  // Without the handshake registers nothing can hold traffic off at start-up.
  assign modbus_enable = !s.hs_enable || s.started;
  assign control_code = s.seen_code;
  assign control_data = s.seen_data;
endmodule

// ---- core/gw_defines.svh ----
`ifndef GW_DEFINES_SVH
`define GW_DEFINES_SVH

`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CONFIG 8'h08
`define ADDR_MB_INDEX 8'h0C
`define ADDR_MB_DATA 8'h10
`define ADDR_MB_CTRL 8'h14

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define CONFIG_HS_ENABLE 0
`define CONFIG_RESET 1'b1
`define MB_GO 0
`define MB_BUSY 0
`define MB_DONE 1
`define MB_ACCEPTED 2

`define CODE_RETRANS 5'h00
`define CODE_ONE_MISSING 5'h01
`define CODE_MANY_MISSING 5'h02
`define CODE_OVERRUN 5'h03
`define CODE_OTHER 5'h04
`define CODE_NO_ERROR 5'h1F
`define DATA_RESET 8'h00

`define MB_WORDS 116
`define MB_HDR_WORDS 7'h10
`define MB_W_INFO 7'h01
`define MB_W_CMD 7'h02
`define MB_W_SIZE 7'h03
`define MB_W_FCOUNT 7'h04
`define MB_W_FNUM 7'h05
`define MB_INFO_CMD 16'h4002
`define MB_INFO_RSP 16'h0002
`define MB_INFO_REJECT 16'h8002
`define MB_CMD_IN_MAP 16'h0004
`define MB_FRAME_ONE 16'h0001
`define MB_MAX_BYTES 16'h00C8
`define MAP_ATTRS 50
`define PARAM_IN_BYTES 17'h00200

`endif

// ---- core/gw_pkg.sv ----
package gw_pkg;

  typedef struct packed {
    logic toggle;
    logic confirm;
    logic data_valid;
    logic [4:0] code;
    logic [7:0] data;
  } status_word_type;

  typedef struct packed {
    logic confirm;
    logic toggle;
    logic data_valid;
    logic [4:0] code;
    logic [7:0] data;
  } control_word_type;

  typedef struct packed {
    logic [7:0] retrans_count;
    logic [7:0] missing_count;
    logic [7:0] missing_addr;
    logic overrun;
    logic [7:0] overrun_addr;
    logic unknown;
    logic [7:0] unknown_addr;
  } subnet_event_type;

  typedef struct packed {
    logic exists;
    logic [15:0] offset;
    logic [15:0] length;
  } map_entry_type;

  typedef struct packed {
    logic en;
    logic [5:0] index;
    map_entry_type entry;
  } map_write_type;

  typedef enum logic [3:0] {
    MAP_IDLE = 4'b0001,
    MAP_CHECK = 4'b0010,
    MAP_ENTRY = 4'b0100,
    MAP_DONE = 4'b1000
  } mapper_state_type;

endpackage

// ---- core/map_table.sv ----
`timescale 1ns/10ps
`include "gw_defines.svh"
module map_table (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input gw_pkg::map_write_type wr,
  input wire logic [5:0] lookup_attr,
  output gw_pkg::map_entry_type lookup_entry,
  output logic default_poll_mode
);
  typedef struct packed {
    gw_pkg::map_entry_type [`MAP_ATTRS-1:0] entries;
    logic mapped_any;
    gw_pkg::map_entry_type result;
  } table_state_type;

  table_state_type s;
  table_state_type next_s;

  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.entries = '0;
      next_s.mapped_any = 1'b1;
    end
    if (wr.en && wr.index < 6'(`MAP_ATTRS)) begin
      next_s.entries[wr.index] = wr.entry;
    end
    // Attribute numbers start at 1; attribute 0 and out-of-range ones never exist.
    if (lookup_attr != 6'h00 && lookup_attr <= 6'(`MAP_ATTRS)) begin
      next_s.result = s.entries[lookup_attr - 6'h01];
    end else begin
      next_s.result = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lookup_entry = s.result;
  assign default_poll_mode = !s.mapped_any;
endmodule

// ---- core/status_encoder.sv ----
`timescale 1ns/10ps
`include "gw_defines.svh"
module status_encoder (
  input wire logic aclk,
  input wire logic aresetn,
  input gw_pkg::subnet_event_type events,
  output logic [4:0] code,
  output logic [7:0] data
);
  typedef struct packed {
    logic [4:0] code;
    logic [7:0] data;
  } enc_state_type;

  enc_state_type s;
  enc_state_type next_s;

  // Missing nodes outrank the other faults because they stall polling entirely.
  always_comb begin
    next_s = s;
    if (events.missing_count > 8'h01) begin
      next_s.code = `CODE_MANY_MISSING;
      next_s.data = events.missing_count;
    end else if (events.missing_count == 8'h01) begin
      next_s.code = `CODE_ONE_MISSING;
      next_s.data = events.missing_addr;
    end else if (events.overrun) begin
      next_s.code = `CODE_OVERRUN;
      next_s.data = events.overrun_addr;
    end else if (events.unknown) begin
      next_s.code = `CODE_OTHER;
      next_s.data = events.unknown_addr;
    end else if (events.retrans_count != 8'h00) begin
      next_s.code = `CODE_RETRANS;
      next_s.data = events.retrans_count;
    end else begin
      next_s.code = `CODE_NO_ERROR;
      next_s.data = `DATA_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s.code <= `CODE_NO_ERROR;
      s.data <= `DATA_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign code = s.code;
  assign data = s.data;
endmodule

// ---- sim/gateway_status_handshake_mapper_sva.sv ----
`timescale 1ns/10ps
module mapper_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input gw_pkg::map_entry_type lookup_entry,
  input wire logic default_poll_mode,
  input wire logic modbus_enable
);
  logic [3:0] wcnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since the last data beat, so traffic start can be tied to a host write.
  always_ff @(posedge aclk) begin
    if (!aresetn || (wvalid && wready)) begin
      wcnt <= 4'h0;
    end else if (wcnt != 4'hF) begin
      wcnt <= wcnt + 4'h1;
    end
  end
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write not answered");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_write_closed: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during answer");
  a_refused_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("refused read carries data");
  a_gate_startup: assert property ($rose(modbus_enable) |-> wcnt <= 4'h4)
    else $error("traffic enabled without host write");
  a_zero_absent: assert property (lookup_entry.exists |-> lookup_entry.length != 16'h0)
    else $error("zero length entry exists");
  a_bound_kept: assert property (lookup_entry.exists |->
    {1'h0, lookup_entry.offset} + {1'h0, lookup_entry.length} <= 17'h00200)
    else $error("entry beyond input area");
  a_poll_sticks: assert property (!default_poll_mode |=> !default_poll_mode)
    else $error("default poll mode returned");
  cover property ($rose(modbus_enable));
  cover property ($fell(default_poll_mode));
  cover property (lookup_entry.exists);
endmodule

bind gateway_status_handshake_mapper mapper_sva mapper_sva_i (.*);

// ---- sim/gateway_status_handshake_mapper_tb.sv ----
`timescale 1ns/10ps
module gateway_status_handshake_mapper_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, all_data_updated, default_poll_mode, modbus_enable;
  logic [7:0] awaddr, araddr, control_data;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [5:0] lookup_attr;
  logic [4:0] control_code;
  logic [15:0] ctl;
  logic [15:0] mb [12];
  logic t, sdv;
  gw_pkg::subnet_event_type events;
  gw_pkg::map_entry_type lookup_entry;
  int n_fail, checks_done, cyc;
  gateway_status_handshake_mapper gateway_status_handshake_mapper_i (.*);
  host_model host_model_i (.*);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] e);
    host_model_i.rd(a, d, r);
    chk(name, 33'(d), {17'h00000, e});
    chk("rresp", 33'(r), 33'h0);
  endtask
  task automatic ack();
    ctl[15] = t;
    host_model_i.wr(8'h00, ctl, r);
  endtask
  task automatic post(input gw_pkg::subnet_event_type ev, input logic [4:0] c,
                      input logic [7:0] v, input logic do_ack);
    events <= ev;
    repeat (4) @(posedge aclk);
    t = ~t;
    rdchk("status", 8'h04, {t, ctl[14], sdv, c, v});
    if (do_ack) ack();
  endtask
  task automatic mb_go(output logic [31:0] st);
    host_model_i.wr(8'h14, 16'h0001, r);
    do host_model_i.rd(8'h14, st, r); while (st[1] !== 1'h1);
  endtask
  task complete_run();
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {aclk, aresetn, all_data_updated, lookup_attr, events, t, sdv} = '0;
    // Three entries only: the issuer stops at the highest attribute it wants.
    mb = '{16'h0001, 16'h4002, 16'h0004, 16'h000C, 16'h0001, 16'h0001,
           16'h0010, 16'h0004, 16'h0000, 16'h0000, 16'h01FE, 16'h0004};
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("modbus_enable", 33'(modbus_enable), 33'h0);
    chk("default_poll_mode", 33'(default_poll_mode), 33'h1);
    rdchk("status", 8'h04, 16'h1F00);
    rdchk("config", 8'h08, 16'h0001);
    ctl = 16'h7107;
    host_model_i.wr(8'h00, ctl, r);
    repeat (2) @(posedge aclk);
    rdchk("status", 8'h04, 16'h5F00);
    chk("modbus_enable", 33'(modbus_enable), 33'h1);
    chk("control_code", 33'(control_code), 33'h11);
    chk("control_data", 33'(control_data), 33'h07);
    post('{retrans_count: 8'h09, default: '0}, 5'h00, 8'h09, 1'h1);
    post('{unknown: 1'h1, unknown_addr: 8'h22, default: '0}, 5'h04, 8'h22, 1'h1);
    post('{overrun: 1'h1, overrun_addr: 8'h33, default: '0}, 5'h03, 8'h33, 1'h1);
    post('{missing_count: 8'h01, missing_addr: 8'h05, default: '0}, 5'h01, 8'h05, 1'h1);
    post('{missing_count: 8'h03, default: '0}, 5'h02, 8'h03, 1'h1);
    post('{retrans_count: 8'h01, default: '0}, 5'h00, 8'h01, 1'h0);
    events <= '{retrans_count: 8'h02, default: '0};
    repeat (4) @(posedge aclk);
    rdchk("status", 8'h04, {t, ctl[14], sdv, 13'h0001});
    ack();
    post('{retrans_count: 8'h02, default: '0}, 5'h00, 8'h02, 1'h1);
    // The encoder lags its inputs by a cycle, so the flag follows a cycle later to post once.
    events <= '0;
    @(posedge aclk);
    all_data_updated <= 1'h1;
    sdv = 1'h1;
    post('0, 5'h1F, 8'h00, 1'h1);
    ctl[14:13] = 2'h0;
    host_model_i.wr(8'h00, ctl, r);
    sdv = 1'h0;
    post('0, 5'h1F, 8'h00, 1'h1);
    host_model_i.wr(8'h18, 16'h1234, r);
    chk("unmapped bresp", 33'(r), 33'h2);
    host_model_i.rd(8'h18, d, r);
    chk("unmapped rresp", 33'(r), 33'h2);
    chk("unmapped read", 33'(d), 33'h0);
    host_model_i.wr(8'h04, 16'hFFFF, r);
    rdchk("status", 8'h04, {t, ctl[14], sdv, 13'h1F00});
    host_model_i.wr(8'h0C, 16'h0000, r);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) host_model_i.wr(8'h0C, 16'h0010, r);
      host_model_i.wr(8'h10, mb[i], r);
    end
    mb_go(d);
    chk("mailbox accepted", 33'(d), 33'h6);
    chk("default_poll_mode", 33'(default_poll_mode), 33'h0);
    host_model_i.wr(8'h0C, 16'h0001, r);
    rdchk("answer info", 8'h10, 16'h0002);
    host_model_i.wr(8'h0C, 16'h0010, r);
    rdchk("answer offset", 8'h10, 16'h0010);
    host_model_i.wr(8'h0C, 16'h0014, r);
    rdchk("invalid offset", 8'h10, 16'h0000);
    for (int a = 1; a <= 3; a++) begin
      lookup_attr <= 6'(a);
      repeat (2) @(posedge aclk);
      chk("lookup_entry", lookup_entry, (a == 1) ? 33'h100100004 : 33'h0);
    end
    host_model_i.wr(8'h0C, 16'h0002, r);
    host_model_i.wr(8'h10, 16'h0005, r);
    mb_go(d);
    chk("mailbox refused", 33'(d), 33'h2);
    host_model_i.wr(8'h0C, 16'h0001, r);
    rdchk("refused info", 8'h10, 16'h8002);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("modbus_enable", 33'(modbus_enable), 33'h0);
    chk("default_poll_mode", 33'(default_poll_mode), 33'h1);
    host_model_i.wr(8'h08, 16'h0000, r);
    chk("modbus_enable", 33'(modbus_enable), 33'h1);
    {ctl, t, sdv} = '0;
    // With the handshake registers off, a new posting does not wait for a confirm.
    post('{missing_count: 8'h01, missing_addr: 8'h44, default: '0}, 5'h01, 8'h44, 1'h0);
    post('{overrun: 1'h1, overrun_addr: 8'h55, default: '0}, 5'h03, 8'h55, 1'h0);
    complete_run();
  end
endmodule

// ---- sim/host_model.sv ----
`timescale 1ns/10ps
module host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // Handshakes are judged at the rising edge itself, and each signal is released only after it.
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
    logic hb;
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      hb = bvalid;
      r = bresp;
    end while (!hb);
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hr;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      hr = rvalid;
      d = rdata;
      r = rresp;
    end while (!hr);
    rready <= 1'h0;
    @(posedge aclk);
  endtask
endmodule
